/* File: asie_pkg.sv */
package asie_pkg;

  // Instruction parcel layout
  localparam int PARCEL_W = 16;
  localparam int OPC_LSB  = 9;
  localparam int OPC_W    = 7;
  localparam int I_LSB    = 6;
  localparam int J_LSB    = 3;
  localparam int K_LSB    = 0;
  localparam int FLD_W    = 3;
  localparam int JK_W     = 6;
  localparam int CONST_W  = 22;

  // Opcodes handled here (octal 031 .. 044)
  localparam logic [6:0] OPC_A_SUB   = 7'h19;
  localparam logic [6:0] OPC_A_MUL   = 7'h1a;
  localparam logic [6:0] OPC_CHAN    = 7'h1b;
  localparam logic [6:0] OPC_B_LOAD  = 7'h1c;
  localparam logic [6:0] OPC_B_STORE = 7'h1d;
  localparam logic [6:0] OPC_T_LOAD  = 7'h1e;
  localparam logic [6:0] OPC_T_STORE = 7'h1f;
  localparam logic [6:0] OPC_S_IMM   = 7'h20;
  localparam logic [6:0] OPC_S_NIMM  = 7'h21;
  localparam logic [6:0] OPC_MASK_R  = 7'h22;
  localparam logic [6:0] OPC_MASK_L  = 7'h23;
  localparam logic [6:0] OPC_S_AND   = 7'h24;

  // Register files
  localparam int SCALAR_W = 64;
  localparam int NUM_REGS = 8;
  localparam int NUM_SAVE = 64;
  localparam int ADDR_W   = 24;
  localparam int CHAN_W   = 6;

  // Values after reset
  localparam logic [63:0] S_RESET   = 64'h0;
  localparam logic [5:0]  IDX_RESET = 6'h00;

  typedef enum logic [1:0] {
    ASIE_IDLE = 2'b00,
    ASIE_CHAN = 2'b01,
    ASIE_XFER = 2'b10,
    ASIE_WAIT = 2'b11
  } asie_state_t;

endpackage

/* File: asie_save_file.sv */
`timescale 1ns/1ps
module asie_save_file
  import asie_pkg::*;
#(
  parameter int W     = SCALAR_W,
  parameter int DEPTH = NUM_SAVE
) (
  // Clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     arst_n,
  // Write side
  input  wire logic                     we,
  input  wire logic [$clog2(DEPTH)-1:0] widx,
  input  wire logic [W-1:0]             wdata,
  // Read side
  input  wire logic [$clog2(DEPTH)-1:0] ridx,
  output logic      [W-1:0]             rdata
);

  logic [W-1:0] mem_ff [DEPTH];

  if (W < 1 || DEPTH < 2) begin : g_chk
    $error("asie_save_file: bad geometry");
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int n = 0; n < DEPTH; n++) begin
        mem_ff[n] <= '0;
      end
    end else if (we) begin
      mem_ff[widx] <= wdata;
    end
  end

  assign rdata = mem_ff[ridx];

endmodule

/* File: asie_mask_gen.sv */
`timescale 1ns/1ps
module asie_mask_gen
  import asie_pkg::*;
#(
  parameter int W  = SCALAR_W,
  parameter int CW = JK_W
) (
  // Count field and selected form
  input  wire logic [CW-1:0] cnt,
  input  wire logic          from_left,
  // Result
  output logic      [W-1:0]  mask
);

  logic [W-1:0] right_ones;

  if (W != (1 << CW)) begin : g_chk
    $error("asie_mask_gen: W must be 2**CW");
  end

  // Ones from the right, width W-cnt; its inverse is ones from the left of width cnt
  assign right_ones = {W{1'b1}} >> cnt;
  assign mask       = from_left ? ~right_ones : right_ones;

endmodule

/* File: asie_exec.sv */
`timescale 1ns/1ps
module asie_exec
  import asie_pkg::*;
#(
  parameter int AW  = ADDR_W,
  parameter int CHW = CHAN_W
) (
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                arst_n,
  // Instruction stream
  input  wire logic                instr_valid,
  input  wire logic [15:0]         instr_parcel,
  input  wire logic [15:0]         instr_const,
  output logic                     instr_ready,
  // Register preload from other units
  input  wire logic                ext_we,
  input  wire logic                ext_scalar,
  input  wire logic [2:0]          ext_idx,
  input  wire logic [63:0]         ext_data,
  // Write-back view
  output logic                     wb_valid,
  output logic                     wb_scalar,
  output logic [2:0]               wb_idx,
  output logic [63:0]              wb_data,
  // Central memory
  output logic                     mem_req,
  output logic                     mem_we,
  output logic [AW-1:0]            mem_addr,
  output logic [63:0]              mem_wdata,
  input  wire logic                mem_ack,
  input  wire logic [63:0]         mem_rdata,
  // Channel status
  input  wire logic [CHW-1:0]      interrupting_channel_number,
  output logic [CHW-1:0]           chan_sel,
  input  wire logic [AW-1:0]       channel_current_address,
  input  wire logic                channel_error_flag
);

  localparam logic [AW-1:0] ADDR_ONE  = AW'(1);
  localparam logic [AW-1:0] ADDR_ZERO = '0;

  if (AW < 8 || AW > SCALAR_W || CHW < 1 || CHW > AW) begin : g_chk
    $error("asie_exec: unsupported AW or CHW");
  end

  // Architectural state
  logic [AW-1:0]  a_ff [NUM_REGS];
  logic [63:0]    s_ff [NUM_REGS];
  asie_state_t    state_ff;
  asie_state_t    nxt_state;
  logic           instr_ready_ff;
  logic           nxt_ready;

  // Pending operation of a multi-cycle instruction
  logic [2:0]     pend_i_ff;
  logic           pend_err_ff;
  logic           xfer_store_ff;
  logic           xfer_tsave_ff;
  logic [AW-1:0]  xfer_cnt_ff;
  logic [AW-1:0]  xfer_addr_ff;
  logic [5:0]     xfer_idx_ff;

  // Port registers
  logic           wb_valid_ff;
  logic           wb_scalar_ff;
  logic [2:0]     wb_idx_ff;
  logic [63:0]    wb_data_ff;
  logic           mem_req_ff;
  logic           mem_we_ff;
  logic [AW-1:0]  mem_addr_ff;
  logic [63:0]    mem_wdata_ff;
  logic [CHW-1:0] chan_sel_ff;

  // Field decode
  function automatic logic [2:0] fld(input logic [15:0] p, input int lsb);
    fld = p[lsb +: FLD_W];
  endfunction

  function automatic logic is_xfer(input logic [6:0] op);
    is_xfer = (op == OPC_B_LOAD) || (op == OPC_B_STORE) ||
              (op == OPC_T_LOAD) || (op == OPC_T_STORE);
  endfunction

  logic [6:0]       opc;
  logic [2:0]       fi;
  logic [2:0]       fj;
  logic [2:0]       fk;
  logic [JK_W-1:0]  fjk;
  logic [63:0]      long_const;
  logic             accept;

  assign opc        = instr_parcel[OPC_LSB +: OPC_W];
  assign fi         = fld(instr_parcel, I_LSB);
  assign fj         = fld(instr_parcel, J_LSB);
  assign fk         = fld(instr_parcel, K_LSB);
  assign fjk        = {fj, fk};
  assign long_const = 64'({fjk, instr_const});
  assign accept     = instr_valid && instr_ready_ff && (state_ff == ASIE_IDLE);

  // Operand fetch with field-zero substitution for 031
  logic [AW-1:0]     sub_lhs;
  logic [AW-1:0]     sub_rhs;
  logic [2*AW-1:0]   full_prod;
  logic [63:0]       mask_val;

  assign sub_lhs   = (fj == 3'h0) ? ADDR_ZERO : a_ff[fj];
  assign sub_rhs   = (fk == 3'h0) ? ADDR_ONE  : a_ff[fk];
  assign full_prod = a_ff[fj] * a_ff[fk];

  asie_mask_gen #(
    .W  (SCALAR_W),
    .CW (JK_W)
  ) u_mask (
    .cnt       (fjk),
    .from_left (opc == OPC_MASK_L),
    .mask      (mask_val)
  );

  // Save files; the address-save file holds address-width words
  logic           b_we;
  logic           t_we;
  logic [AW-1:0]  b_rdata;
  logic [63:0]    t_rdata;

  asie_save_file #(
    .W     (AW),
    .DEPTH (NUM_SAVE)
  ) u_bsave (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .we       (b_we),
    .widx     (xfer_idx_ff),
    .wdata    (mem_rdata[AW-1:0]),
    .ridx     (xfer_idx_ff),
    .rdata    (b_rdata)
  );

  asie_save_file #(
    .W     (SCALAR_W),
    .DEPTH (NUM_SAVE)
  ) u_tsave (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .we       (t_we),
    .widx     (xfer_idx_ff),
    .wdata    (mem_rdata),
    .ridx     (xfer_idx_ff),
    .rdata    (t_rdata)
  );

  logic xfer_beat;
  assign xfer_beat = (state_ff == ASIE_WAIT) && mem_ack;
  assign b_we      = xfer_beat && !xfer_store_ff && !xfer_tsave_ff;
  assign t_we      = xfer_beat && !xfer_store_ff && xfer_tsave_ff;

  // Result selection for address and scalar destinations
  logic           a_we;
  logic [2:0]     a_widx;
  logic [AW-1:0]  a_wdata;
  logic           s_we;
  logic [63:0]    s_wdata;

  always_comb begin
    a_we    = 1'b0;
    a_widx  = fi;
    a_wdata = ADDR_ZERO;
    s_we    = 1'b0;
    s_wdata = S_RESET;
    if (accept) begin
      case (opc)
        OPC_A_SUB: begin
          a_we    = 1'b1;
          a_wdata = sub_lhs - sub_rhs;
        end
        OPC_A_MUL: begin
          a_we    = 1'b1;
          a_wdata = full_prod[AW-1:0];
        end
        OPC_CHAN: begin
          a_we    = (fj == 3'h0);
          a_wdata = AW'(interrupting_channel_number);
        end
        OPC_S_IMM: begin
          s_we    = 1'b1;
          s_wdata = long_const;
        end
        OPC_S_NIMM: begin
          s_we    = 1'b1;
          s_wdata = ~long_const;
        end
        OPC_MASK_R, OPC_MASK_L: begin
          s_we    = 1'b1;
          s_wdata = mask_val;
        end
        OPC_S_AND: begin
          s_we    = 1'b1;
          s_wdata = s_ff[fj] & s_ff[fk];
        end
        default: begin
          a_we = 1'b0;
        end
      endcase
    end else if (state_ff == ASIE_CHAN) begin
      a_we    = 1'b1;
      a_widx  = pend_i_ff;
      a_wdata = pend_err_ff ? AW'(channel_error_flag)
                            : channel_current_address;
    end
  end

  // Address registers; instruction results win over preload
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int n = 0; n < NUM_REGS; n++) begin
        a_ff[n] <= '0;
      end
    end else if (a_we) begin
      a_ff[a_widx] <= a_wdata;
    end else if (ext_we && !ext_scalar) begin
      a_ff[ext_idx] <= ext_data[AW-1:0];
    end
  end

  // Scalar registers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int n = 0; n < NUM_REGS; n++) begin
        s_ff[n] <= S_RESET;
      end
    end else if (s_we) begin
      s_ff[fi] <= s_wdata;
    end else if (ext_we && ext_scalar) begin
      s_ff[ext_idx] <= ext_data;
    end
  end

  // Write-back view mirrors every address and scalar register write made by an instruction
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_valid_ff  <= 1'b0;
      wb_scalar_ff <= 1'b0;
      wb_idx_ff    <= 3'h0;
      wb_data_ff   <= 64'h0;
    end else begin
      wb_valid_ff  <= a_we || s_we;
      wb_scalar_ff <= s_we;
      wb_idx_ff    <= a_we ? a_widx : fi;
      wb_data_ff   <= s_we ? s_wdata : 64'(a_wdata);
    end
  end

  // Sequencer for channel reads and block transfers
  always_comb begin
    nxt_state = state_ff;
    nxt_ready = instr_ready_ff;
    case (state_ff)
      ASIE_IDLE: begin
        if (accept && opc == OPC_CHAN && fj != 3'h0) begin
          nxt_state = ASIE_CHAN;
          nxt_ready = 1'b0;
        end else if (accept && is_xfer(opc) && a_ff[fi] != ADDR_ZERO) begin
          nxt_state = ASIE_XFER;
          nxt_ready = 1'b0;
        end
      end
      ASIE_CHAN: begin
        nxt_state = ASIE_IDLE;
        nxt_ready = 1'b1;
      end
      ASIE_XFER: begin
        nxt_state = ASIE_WAIT;
      end
      ASIE_WAIT: begin
        if (mem_ack) begin
          nxt_state = (xfer_cnt_ff == ADDR_ONE) ? ASIE_IDLE : ASIE_XFER;
          nxt_ready = (xfer_cnt_ff == ADDR_ONE);
        end
      end
      default: begin
        nxt_state = ASIE_IDLE;
        nxt_ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff       <= ASIE_IDLE;
      instr_ready_ff <= 1'b0;
    end else begin
      state_ff       <= nxt_state;
      instr_ready_ff <= (state_ff == ASIE_IDLE && !instr_ready_ff) ? 1'b1 : nxt_ready;
    end
  end

  // Channel query: select is held until the next query, answer sampled one cycle after it is set
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_i_ff   <= 3'h0;
      pend_err_ff <= 1'b0;
      chan_sel_ff <= '0;
    end else if (accept && opc == OPC_CHAN) begin
      pend_i_ff   <= fi;
      pend_err_ff <= (fk == 3'h1);
      chan_sel_ff <= a_ff[fj][CHW-1:0];
    end
  end

  // Transfer bookkeeping: count from destination field, base from register zero
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      xfer_store_ff <= 1'b0;
      xfer_tsave_ff <= 1'b0;
      xfer_cnt_ff   <= '0;
      xfer_addr_ff  <= '0;
      xfer_idx_ff   <= IDX_RESET;
    end else if (accept && is_xfer(opc)) begin
      xfer_store_ff <= (opc == OPC_B_STORE) || (opc == OPC_T_STORE);
      xfer_tsave_ff <= (opc == OPC_T_LOAD) || (opc == OPC_T_STORE);
      xfer_cnt_ff   <= a_ff[fi];
      xfer_addr_ff  <= a_ff[0];
      xfer_idx_ff   <= fjk;
    end else if (xfer_beat) begin
      xfer_cnt_ff  <= xfer_cnt_ff - ADDR_ONE;
      xfer_addr_ff <= xfer_addr_ff + ADDR_ONE;
      // Index wraps within the save file rather than faulting
      xfer_idx_ff  <= xfer_idx_ff + 6'h01;
    end
  end

  // Memory port: request held until acknowledged
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_req_ff   <= 1'b0;
      mem_we_ff    <= 1'b0;
      mem_addr_ff  <= '0;
      mem_wdata_ff <= 64'h0;
    end else if (state_ff == ASIE_XFER) begin
      mem_req_ff   <= 1'b1;
      mem_we_ff    <= xfer_store_ff;
      mem_addr_ff  <= xfer_addr_ff;
      mem_wdata_ff <= xfer_tsave_ff ? t_rdata
                                    : 64'(b_rdata);
    end else if (xfer_beat) begin
      mem_req_ff <= 1'b0;
      mem_we_ff  <= 1'b0;
    end
  end

  assign instr_ready = instr_ready_ff;
  assign wb_valid    = wb_valid_ff;
  assign wb_scalar   = wb_scalar_ff;
  assign wb_idx      = wb_idx_ff;
  assign wb_data     = wb_data_ff;
  assign mem_req     = mem_req_ff;
  assign mem_we      = mem_we_ff;
  assign mem_addr    = mem_addr_ff;
  assign mem_wdata   = mem_wdata_ff;
  assign chan_sel    = chan_sel_ff;

endmodule

/* File: asie_exec_properties.sv */
`timescale 1ns/1ps
module asie_exec_properties
  import asie_pkg::*;
#(
  parameter int AW  = ADDR_W,
  parameter int CHW = CHAN_W
) (
  // Clock and reset
  input wire logic           core_clk,
  input wire logic           arst_n,
  // Instruction stream
  input wire logic           instr_valid,
  input wire logic [15:0]    instr_parcel,
  input wire logic [15:0]    instr_const,
  input wire logic           instr_ready,
  // Write-back view
  input wire logic           wb_valid,
  input wire logic           wb_scalar,
  input wire logic [2:0]     wb_idx,
  input wire logic [63:0]    wb_data,
  // Memory and channel
  input wire logic           mem_req,
  input wire logic           mem_we,
  input wire logic [AW-1:0]  mem_addr,
  input wire logic [63:0]    mem_wdata,
  input wire logic           mem_ack,
  input wire logic [CHW-1:0] interrupting_channel_number,
  input wire logic           channel_error_flag
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  logic       acc;
  logic [6:0] opc;
  assign acc = instr_valid && instr_ready;
  assign opc = instr_parcel[15:9];

  chan_wait_a: assert property (acc && opc == OPC_CHAN && instr_parcel[5:3] != 3'h0 |=>
    !instr_ready ##1 (wb_valid && wb_idx == $past(instr_parcel[8:6], 2))) else $error("channel query timing wrong");
  chan_num_a: assert property (acc && opc == OPC_CHAN && instr_parcel[5:3] == 3'h0 |=>
    wb_valid && wb_data == 64'($past(interrupting_channel_number))) else $error("channel number wrong");
  err_flag_a: assert property (acc && opc == OPC_CHAN && instr_parcel[5:3] != 3'h0 && instr_parcel[2:0] == 3'h1
    |=> ##1 wb_data == 64'($past(channel_error_flag))) else $error("error flag wrong");
  imm_load_a: assert property (acc && opc == OPC_S_IMM |=> wb_valid && wb_scalar &&
    wb_data == {42'h0, $past(instr_parcel[5:0]), $past(instr_const)}) else $error("immediate wrong");
  imm_compl_a: assert property (acc && opc == OPC_S_NIMM |=>
    wb_data == ~{42'h0, $past(instr_parcel[5:0]), $past(instr_const)}) else $error("complement wrong");
  minus_one_a: assert property (acc && opc == OPC_A_SUB && instr_parcel[5:0] == 6'h00 |=>
    wb_valid && wb_data == 64'hffffff) else $error("minus one wrong");
  mask_right_a: assert property (acc && opc == OPC_MASK_R |=>
    wb_data == (~64'h0 >> $past(instr_parcel[5:0]))) else $error("right mask wrong");
  mask_left_a: assert property (acc && opc == OPC_MASK_L |=>
    wb_data == ~(~64'h0 >> $past(instr_parcel[5:0]))) else $error("left mask wrong");
  mem_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) &&
    $stable(mem_we) && $stable(mem_wdata)) else $error("memory request not held");
  word_seq_a: assert property (mem_req && mem_ack |=> !mem_req ##1
    (!mem_req || mem_addr == $past(mem_addr, 2) + 1'b1)) else $error("word address not sequential");
endmodule

bind asie_exec asie_exec_properties #(.AW(AW), .CHW(CHW)) chk (
  .core_clk, .arst_n, .instr_valid, .instr_parcel, .instr_const, .instr_ready, .wb_valid, .wb_scalar,
  .wb_idx, .wb_data, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .interrupting_channel_number,
  .channel_error_flag
);

/* File: asie_mem_model.sv */
`timescale 1ns/1ps
module asie_mem_model #(
  parameter int AW  = 24,
  parameter int CHW = 6
) (
  // Clock and reset
  input wire logic           core_clk,
  input wire logic           arst_n,
  // Memory port
  input wire logic           mem_req,
  input wire logic           mem_we,
  input wire logic [AW-1:0]  mem_addr,
  input wire logic [63:0]    mem_wdata,
  output logic               mem_ack,
  output logic [63:0]        mem_rdata,
  // Channel status
  input wire logic [CHW-1:0] chan_sel,
  output logic [AW-1:0]      channel_current_address,
  output logic               channel_error_flag
);
  logic [63:0] mem [64];
  logic [1:0]  dly;
  logic [1:0]  nw;

  initial for (int n = 0; n < 64; n++) mem[n] = {32'h9e3779b9 * n, 32'h7f4a7c15 ^ n};

  assign channel_current_address = AW'({4{chan_sel}});
  assign channel_error_flag      = ^chan_sel;

  // Latency cycles through 0..3 so both prompt and slow answers occur
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_ack   <= 1'b0;
      mem_rdata <= 64'h0;
      dly       <= 2'h0;
      nw        <= 2'h0;
    end else if (mem_req && !mem_ack && dly >= nw) begin
      mem_ack <= 1'b1;
      dly     <= 2'h0;
      nw      <= nw + 2'h1;
      if (mem_we)
        mem[mem_addr[5:0]] <= mem_wdata;
      else
        mem_rdata <= mem[mem_addr[5:0]];
    end else begin
      mem_ack   <= 1'b0;
      // Stale data is inverted each cycle outside an answer, so it equals the answered word every second cycle
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack)
        dly <= dly + 2'h1;
    end
  end
endmodule

/* File: asie_exec_bench.sv */
`timescale 1ns/1ps
module asie_exec_bench;
  import asie_pkg::*;
  logic        core_clk, arst_n, instr_valid, instr_ready, ext_we, ext_scalar, wb_valid, wb_scalar;
  logic        mem_req, mem_we, mem_ack, channel_error_flag;
  logic [15:0] instr_parcel, instr_const, c;
  logic [2:0]  ext_idx, wb_idx;
  logic [63:0] ext_data, wb_data, mem_wdata, mem_rdata;
  logic [23:0] mem_addr, channel_current_address;
  logic [5:0]  interrupting_channel_number, chan_sel;
  logic [23:0] a_sh [8];
  logic [63:0] s_sh [8];
  logic [67:0] expq [$];
  int          mismatches = 0;
  int          samples_checked = 0;
  int          seed = 56263;
  int          cyc = 0;
  int          jks [4] = '{0, 1, 32, 63};

  asie_exec uut (.core_clk, .arst_n, .instr_valid, .instr_parcel, .instr_const, .instr_ready, .ext_we,
    .ext_scalar, .ext_idx, .ext_data, .wb_valid, .wb_scalar, .wb_idx, .wb_data, .mem_req, .mem_we, .mem_addr,
    .mem_wdata, .mem_ack, .mem_rdata, .interrupting_channel_number, .chan_sel, .channel_current_address,
    .channel_error_flag);
  asie_mem_model mem_m (.core_clk, .arst_n, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata,
    .chan_sel, .channel_current_address, .channel_error_flag);

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic check(input logic [67:0] seen, input logic [67:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Note an expected write-back and track it in the shadow files
  task automatic pw(input logic sc, input logic [2:0] i, input logic [63:0] d);
    expq.push_back({sc, i, d});
    if (sc)
      s_sh[i] = d;
    else
      a_sh[i] = d[23:0];
  endtask

  // Valid stays up after return; caller issues again or idles at this edge
  task automatic op(input logic [6:0] o, input logic [2:0] i, j, k, input logic [15:0] cv = 16'h0);
    logic r;
    instr_valid  = 1'b1;
    instr_parcel = {o, i, j, k};
    instr_const  = cv;
    do begin
      r = instr_ready;
      @(negedge core_clk);
    end while (r !== 1'b1);
  endtask

  task automatic drain();
    instr_valid = 1'b0;
    do @(negedge core_clk); while (instr_ready !== 1'b1);
  endtask

  task automatic pre(input logic sc, input logic [2:0] n, input logic [63:0] d);
    ext_we     = 1'b1;
    ext_scalar = sc;
    ext_idx    = n;
    ext_data   = d;
    if (sc)
      s_sh[n] = d;
    else
      a_sh[n] = d[23:0];
    @(negedge core_clk);
  endtask

  always @(negedge core_clk) begin
    if (wb_valid === 1'b1) begin
      if (expq.size() == 0) begin
        mismatches++;
        $display("BAD %0t unexpected write-back", $time);
      end else
        check({wb_scalar, wb_idx, wb_data}, expq.pop_front());
    end
  end

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      complete_run();
    end
  end

  initial begin
    {instr_valid, ext_we, ext_scalar, ext_idx, ext_data, instr_parcel, instr_const} = '0;
    interrupting_channel_number = 6'($random(seed));
    arst_n = 1'b0;
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    arst_n = 1'b1;
    repeat (2) @(negedge core_clk);
    for (int n = 0; n < 8; n++) begin
      pre(1'b0, 3'(n), 64'($random(seed)));
      pre(1'b1, 3'(n), {$random(seed), $random(seed)});
    end
    ext_we = 1'b0;
    pw(1'b0, 3'd4, 64'(24'(a_sh[2] - a_sh[3])));
    op(OPC_A_SUB, 3'd4, 3'd2, 3'd3);
    pw(1'b0, 3'd5, 64'(24'(24'h0 - a_sh[4])));
    op(OPC_A_SUB, 3'd5, 3'd0, 3'd4);
    pw(1'b0, 3'd6, 64'(24'(a_sh[5] - 24'h1)));
    op(OPC_A_SUB, 3'd6, 3'd5, 3'd0);
    pw(1'b0, 3'd7, 64'hffffff);
    op(OPC_A_SUB, 3'd7, 3'd0, 3'd0);
    pw(1'b0, 3'd2, 64'(24'(a_sh[4] * a_sh[6])));
    op(OPC_A_MUL, 3'd2, 3'd4, 3'd6);
    pw(1'b0, 3'd1, 64'(interrupting_channel_number));
    op(OPC_CHAN, 3'd1, 3'd0, 3'd5);
    pw(1'b0, 3'd2, 64'({4{a_sh[3][5:0]}}));
    op(OPC_CHAN, 3'd2, 3'd3, 3'd0);
    pw(1'b0, 3'd4, 64'({4{a_sh[3][5:0]}}));
    op(OPC_CHAN, 3'd4, 3'd3, 3'd2);
    pw(1'b0, 3'd3, 64'(^a_sh[3][5:0]));
    op(OPC_CHAN, 3'd3, 3'd3, 3'd1);
    for (int m = 0; m < 2; m++) begin
      c = 16'($random(seed));
      pw(1'b1, 3'd6, m ? ~{42'h0, 6'o51, c} : {42'h0, 6'o51, c});
      op(m ? OPC_S_NIMM : OPC_S_IMM, 3'd6, 3'd5, 3'd1, c);
    end
    for (int m = 0; m < 4; m++) begin
      pw(1'b1, 3'(m), ~64'h0 >> jks[m]);
      op(OPC_MASK_R, 3'(m), jks[m][5:3], jks[m][2:0]);
      pw(1'b1, 3'(m + 4), ~(~64'h0 >> jks[m]));
      op(OPC_MASK_L, 3'(m + 4), jks[m][5:3], jks[m][2:0]);
    end
    // Operands chosen so that OR, or passing either one through, gives a different word
    pw(1'b1, 3'd7, s_sh[6] & s_sh[1]);
    op(OPC_S_AND, 3'd7, 3'd6, 3'd1);
    op(7'h7f, 3'd1, 3'd1, 3'd1);
    drain();
    pre(1'b0, 3'd0, 64'd16);
    pre(1'b0, 3'd1, 64'd3);
    ext_we = 1'b0;
    op(OPC_T_LOAD, 3'd1, 3'd7, 3'd6);
    drain();
    pre(1'b0, 3'd0, 64'd40);
    ext_we = 1'b0;
    op(OPC_T_STORE, 3'd1, 3'd7, 3'd6);
    drain();
    for (int n = 0; n < 3; n++)
      check(mem_m.mem[40 + n], mem_m.mem[16 + n]);
    pre(1'b0, 3'd0, 64'd20);
    ext_we = 1'b0;
    op(OPC_B_LOAD, 3'd1, 3'd0, 3'd5);
    drain();
    pre(1'b0, 3'd0, 64'd48);
    ext_we = 1'b0;
    op(OPC_B_STORE, 3'd1, 3'd0, 3'd5);
    drain();
    for (int n = 0; n < 3; n++)
      check(mem_m.mem[48 + n], {40'h0, mem_m.mem[20 + n][23:0]});
    // Zero count: no memory traffic and the stream is never held up
    pre(1'b0, 3'd2, 64'd0);
    ext_we = 1'b0;
    op(OPC_T_LOAD, 3'd2, 3'd0, 3'd0);
    check(68'({instr_ready, mem_req}), 68'h2);
    drain();
    check(68'({instr_ready, mem_req}), 68'h2);
    repeat (4) @(negedge core_clk);
    check(68'(expq.size()), 68'h0);
    complete_run();
  end
endmodule
